//--- design/mcu_reset_pkg.sv
// constants, types and register map of the reset sequencer
package mcu_reset_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // reset_delay_time after the pin is released
  localparam int unsigned RESET_DELAY_NS = 100_000;
  localparam int unsigned RESET_DELAY_CYCLES =
    (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // undervoltage_min_duration, a dip must outlast it
  localparam int unsigned UV_MIN_NS = 1_000_000;
  localparam int unsigned UV_MIN_CYCLES =
    (UV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // undervoltage_threshold choices, one comparator per level
  localparam int unsigned UV_LEVELS = 4;
  localparam int unsigned UV_SEL_DEFAULT = 1;

  localparam int unsigned WDT_PRESCALE = 256;
  localparam int unsigned WDT_BITS = 8;

  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] CMD_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] WDTCNT_OFS = 12'h00C;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned CTRL_WDT_EN_BIT = 0;
  localparam int unsigned CMD_KICK_BIT = 0;
  localparam int unsigned CMD_HALT_BIT = 1;
  localparam int unsigned STAT_TO_BIT = 0;
  localparam int unsigned STAT_PDF_BIT = 1;
  localparam int unsigned STAT_CAUSE_LSB = 2;
  localparam int unsigned STAT_UVEN_BIT = 5;
  localparam int unsigned STAT_RUN_BIT = 6;

  typedef enum logic [2:0] {
    CAUSE_POR,
    CAUSE_PIN,
    CAUSE_UV,
    CAUSE_WDT,
    CAUSE_WDT_HALT
  } cause_t;

  typedef struct packed {
    logic cpuReset;
    logic pcClear;
    logic spClear;
    logic ioPreset;
    logic cpuRun;
  } resetCtl_t;

endpackage

//--- design/undervoltage_filter.sv
// low-supply duration filter
`timescale 1ns/1ps
module undervoltage_filter #(
  parameter int unsigned MIN_CYCLES = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic lowIn,
  output logic trip
);

  localparam int unsigned CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYCLES);

  logic [CW-1:0] lowCount;

  // any high sample restarts the count, so short dips never trip
  always_ff @(posedge mclk) begin
    if (sys_rst || !enable || !lowIn) begin
      lowCount <= '0;
      trip <= 1'b0;
    end else if (lowCount != CNT_MAX) begin
      lowCount <= lowCount + 1'b1;
    end else begin
      trip <= 1'b1;
    end
  end

  uvMinDuration_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(trip) |-> $past(lowCount) == CNT_MAX && $past(lowIn))
    else $error("undervoltage trip before minimum duration");

  uvDisabled_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !enable |=> !trip)
    else $error("undervoltage trip while function disabled");

endmodule

//--- design/mcu_reset_sequencer.sv
// reset source merger, start-up timer and reset flags
//
// Summary of operation
// - A power-on reset clears the program counter so fetch starts at address zero.
// - A power-up presets all port data and direction registers to ones (inputs).
// - After the reset pin returns high, a fixed start-up delay runs before execution.
// - Execution stays stalled while the reset pin is low.
// - A pin reset in operation is a normal-operation reset; execution resumes after it.
// - A pin reset in operation clears the program counter and restarts from zero.
// - A watchdog overflow resets the device.
// - A watchdog reset in operation acts as a pin reset and also sets the time-out flag.
// - A low supply applies a full reset like a pin reset.
// - The low-voltage reset is enabled or disabled by a fixed configuration option.
// - Only a low supply lasting longer than the minimum duration causes a reset.
// - The low-voltage threshold is chosen from a configured set.
// - A power-on reset clears the time-out flag and the power-down flag.
// - A watchdog reset in power-down clears only PC and SP and sets the time-out flag.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mcu_reset_sequencer
  import mcu_reset_pkg::*;
#(
  parameter int unsigned RESET_DELAY = RESET_DELAY_CYCLES,
  parameter int unsigned UV_MIN = UV_MIN_CYCLES,
  parameter bit UV_ENABLE = 1'b1,
  parameter int unsigned UV_SEL = UV_SEL_DEFAULT,
  parameter int unsigned WDT_DIV = WDT_PRESCALE,
  parameter int unsigned WDT_W = WDT_BITS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic externalResetPinN,
  input wire logic [UV_LEVELS-1:0] undervoltageBelow,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output resetCtl_t resetCtl
);

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN,
    ST_HALT
  } seqState_t;

  localparam int unsigned SYNC_W = UV_LEVELS + 1;
  localparam int unsigned DLY_W = $clog2(RESET_DELAY + 1);
  localparam int unsigned PRE_W = $clog2(WDT_DIV + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RESET_DELAY - 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WDT_DIV - 1);

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CTRL_OFS) || (a == CMD_OFS) ||
               (a == STATUS_OFS) || (a == WDTCNT_OFS);
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  wire [SYNC_W-1:0] rawIn = {undervoltageBelow, externalResetPinN};

  // cleared at reset: pin reads low, so power-up waits for the pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  wire pinLow = !syncB[0];
  wire [UV_LEVELS-1:0] uvSync = syncB[SYNC_W-1:1];
  wire uvSelected = uvSync[UV_SEL];
  wire uvTrip;

  undervoltage_filter #(
    .MIN_CYCLES(UV_MIN)
  ) uvFilter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(UV_ENABLE),
    .lowIn(uvSelected),
    .trip(uvTrip)
  );

  // ---------------- sequencer state ----------------
  seqState_t state;
  seqState_t next_state;
  cause_t cause;
  cause_t next_cause;
  logic [DLY_W-1:0] delayCnt;
  logic watchdogTimeoutFlag;
  logic powerDownFlag;

  wire extSource = pinLow || uvTrip;
  wire resetActive = (state == ST_HOLD) || (state == ST_DELAY);
  wire fullReset = resetActive && (cause != CAUSE_WDT_HALT);
  wire delayDone = (state == ST_DELAY) && (delayCnt == DLY_LAST);

  // ---------------- APB decode ----------------
  logic [31:0] ctrlReg;
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire mapped = isMapped(paddr);
  wire wrLow = access && pwrite && pstrb[0];
  wire ctrlWr = wrLow && (paddr == CTRL_OFS);
  wire cmdWr = wrLow && (paddr == CMD_OFS);
  wire wdtKick = cmdWr && pwdata[CMD_KICK_BIT];
  wire haltReq = cmdWr && pwdata[CMD_HALT_BIT];
  wire wdtEnable = ctrlReg[CTRL_WDT_EN_BIT];

  // ---------------- watchdog_timer_unit ----------------
  logic [PRE_W-1:0] wdtPre;
  logic [WDT_W-1:0] watchdogCount;
  wire wdtRunning = wdtEnable && ((state == ST_RUN) || (state == ST_HALT));
  wire wdtTick = wdtRunning && (wdtPre == PRE_LAST);
  wire wdtOverflow = wdtTick && (&watchdogCount);

  // counter restarts after every reset and every kick
  always_ff @(posedge mclk) begin
    if (sys_rst || !wdtRunning || wdtKick) begin
      wdtPre <= '0;
      watchdogCount <= '0;
    end else if (wdtTick) begin
      wdtPre <= '0;
      watchdogCount <= watchdogCount + 1'b1;
    end else begin
      wdtPre <= wdtPre + 1'b1;
    end
  end

  // ---------------- next state ----------------
  // pin beats low supply, both beat the watchdog
  always_comb begin
    next_state = state;
    next_cause = cause;
    case (state)
      ST_HOLD: begin
        if (!extSource) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (extSource) begin
          next_state = ST_HOLD;
          next_cause = pinLow ? CAUSE_PIN : CAUSE_UV;
        end else if (delayDone) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pinLow) begin
          next_state = ST_HOLD;
          next_cause = CAUSE_PIN;
        end else if (uvTrip) begin
          next_state = ST_HOLD;
          next_cause = CAUSE_UV;
        end else if (wdtOverflow) begin
          next_state = ST_DELAY;
          next_cause = CAUSE_WDT;
        end else if (haltReq) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (extSource) begin
          next_state = ST_HOLD;
          next_cause = pinLow ? CAUSE_PIN : CAUSE_UV;
        end else if (wdtOverflow) begin
          next_state = ST_DELAY;
          next_cause = CAUSE_WDT_HALT;
        end
      end
      default: begin
        next_state = ST_HOLD;
        next_cause = CAUSE_POR;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
      cause <= CAUSE_POR;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // system_startup_timer, counts only in the delay state
  always_ff @(posedge mclk) begin
    if (sys_rst || (state != ST_DELAY)) begin
      delayCnt <= '0;
    end else if (!delayDone) begin
      delayCnt <= delayCnt + 1'b1;
    end
  end

  // flags survive pin and low-supply resets; only power-on clears
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      watchdogTimeoutFlag <= 1'b0;
      powerDownFlag <= 1'b0;
    end else begin
      if ((next_cause == CAUSE_WDT || next_cause == CAUSE_WDT_HALT) &&
          next_state == ST_DELAY && !resetActive) begin
        watchdogTimeoutFlag <= 1'b1;
      end
      if (state == ST_RUN && next_state == ST_HALT) begin
        powerDownFlag <= 1'b1;
      end
    end
  end

  // ---------------- reset outputs ----------------
  // a watchdog wake from power-down keeps all but PC and SP
  always_comb begin
    resetCtl.cpuReset = fullReset;
    resetCtl.pcClear = resetActive;
    resetCtl.spClear = resetActive;
    resetCtl.ioPreset = fullReset;
    resetCtl.cpuRun = (state == ST_RUN);
  end

  // ---------------- APB slave ----------------
  wire [31:0] statusWord = {
    25'h0,
    (state == ST_RUN),
    UV_ENABLE,
    cause,
    powerDownFlag,
    watchdogTimeoutFlag
  };

  logic [31:0] readMux;
  always_comb begin
    case (paddr)
      CTRL_OFS: readMux = ctrlReg;
      STATUS_OFS: readMux = statusWord;
      WDTCNT_OFS: readMux = 32'(watchdogCount);
      default: readMux = 32'h0000_0000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrlReg <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrlReg <= {31'h0, pwdata[CTRL_WDT_EN_BIT]};
    end
  end

  // read data captured in setup so it is stable through access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : readMux;
    end
  end

  // ---------------- checks ----------------
  porPcClear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> resetCtl.pcClear && !resetCtl.cpuRun)
    else $error("power-on reset did not clear the program counter");

  porIoPreset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> resetCtl.ioPreset && resetCtl.cpuReset)
    else $error("power-on reset did not preset the ports");

  startDelay_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(resetCtl.cpuRun) |-> $past(state) == ST_DELAY &&
      $past(delayCnt) == DLY_LAST && !$past(extSource))
    else $error("execution resumed without the start-up delay");

  pinStall_a: assert property (@(posedge mclk) disable iff (sys_rst)
    pinLow |=> !resetCtl.cpuRun)
    else $error("execution ran with the reset pin low");

  pinResetKeeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_RUN && pinLow |=> resetCtl.cpuReset &&
      $stable(watchdogTimeoutFlag) && $stable(powerDownFlag))
    else $error("pin reset in operation misbehaved");

  pinPcClear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_RUN && pinLow ##1 pinLow |-> resetCtl.pcClear && resetCtl.spClear)
    else $error("pin reset did not clear the program counter");

  wdtReset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_RUN && wdtOverflow && !extSource |=>
      state == ST_DELAY && resetCtl.cpuReset)
    else $error("watchdog overflow did not reset");

  wdtFlagSet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_RUN && wdtOverflow && !extSource |=>
      watchdogTimeoutFlag && resetCtl.ioPreset && $stable(powerDownFlag))
    else $error("watchdog reset did not set the time-out flag");

  uvReset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_RUN && uvTrip && !pinLow |=>
      resetCtl.cpuReset && resetCtl.ioPreset && cause == CAUSE_UV)
    else $error("low supply did not apply a full reset");

  porFlags_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> !watchdogTimeoutFlag && !powerDownFlag)
    else $error("power-on reset left a reset flag set");

  haltWake_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state == ST_HALT && wdtOverflow && !extSource |=>
      resetCtl.pcClear && resetCtl.spClear && !resetCtl.cpuReset &&
      !resetCtl.ioPreset && watchdogTimeoutFlag && powerDownFlag)
    else $error("watchdog wake from power-down reset too much");

  mergedReset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    extSource |=> resetActive ##1 (resetActive || !$past(extSource)))
    else $error("internal reset dropped while a source was active");

endmodule

//--- testbench/reset_network_model.sv
// external rc reset network and supply comparators facing the sequencer
`timescale 1ns/1ps
module reset_network_model
  import mcu_reset_pkg::*;
#(
  parameter int unsigned RC_CYCLES = 12
) (
  input wire logic mclk,
  input wire logic powerUp,
  input wire logic pressButton,
  input wire logic [UV_LEVELS-1:0] dipMask,
  output logic externalResetPinN,
  output logic [UV_LEVELS-1:0] undervoltageBelow
);
  int unsigned chargeCount;
  // cap charges only once supply is up; a press discharges it at once,
  // so the pin stays low for the full rc time after every release
  always_ff @(posedge mclk) begin
    if (!powerUp || pressButton) begin
      chargeCount <= 0;
    end else if (chargeCount < RC_CYCLES) begin
      chargeCount <= chargeCount + 1;
    end
  end
  assign externalResetPinN = (chargeCount >= RC_CYCLES) && !pressButton;
  assign undervoltageBelow = dipMask;
endmodule

//--- testbench/tb_mcu_reset_sequencer.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module tb_mcu_reset_sequencer;
  import mcu_reset_pkg::*;
  localparam int RD = 4;
  localparam int UVM = 5;
  localparam int WDIV = 4;
  localparam int WW = 3;
  localparam logic [4:0] FULL_RST = 5'h1E;
  localparam logic [4:0] HALT_RST = 5'h0C;
  localparam logic [UV_LEVELS-1:0] SEL_MASK = 4'h1 << UV_SEL_DEFAULT;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic powerUp, pressButton, pinN, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [UV_LEVELS-1:0] dipMask, below;
  resetCtl_t resetCtl;
  int bad_count, samples_checked, n;

  mcu_reset_sequencer #(.RESET_DELAY(RD), .UV_MIN(UVM), .WDT_DIV(WDIV), .WDT_W(WW)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .externalResetPinN(pinN), .undervoltageBelow(below),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetCtl(resetCtl));
  reset_network_model net_u (.mclk(mclk), .powerUp(powerUp), .pressButton(pressButton),
    .dipMask(dipMask), .externalResetPinN(pinN), .undervoltageBelow(below));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkCtl(input logic [4:0] got, input logic [4:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
      output logic [31:0] rdat, output logic perr);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // status low bits: running, uv enable, cause, pdf, to
  task automatic stat(input logic [4:0] exp);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    chkWord({25'h0, rd[6:0]}, {25'h0, 2'b11, exp}, "status");
  endtask

  task automatic stayRun(input int k);
    repeat (k) begin
      @(negedge mclk);
      chkWord({31'h0, resetCtl.cpuRun}, 32'h1, "running");
    end
  endtask

  // watchdog is silenced right after each start so later scenarios are not cut short
  task automatic resumeRun(input logic [4:0] hold, output int cyc);
    cyc = 0;
    while (resetCtl.cpuRun !== 1'b1 && cyc < 200) begin
      chkCtl(resetCtl, hold, "held in reset");
      @(negedge mclk);
      cyc++;
    end
    apb(1'b1, CTRL_OFS, 32'h0, rd, err);
  endtask

  task automatic powerOnTest();
    while (pinN !== 1'b1) begin
      @(negedge mclk);
      chkCtl(resetCtl, FULL_RST, "pin low at power-up");
    end
    resumeRun(FULL_RST, n);
    // two synchroniser edges and one state edge come before the delay itself
    chkWord(32'(n), 32'(RD + 3), "start-up delay");
    stat({CAUSE_POR, 1'b0, 1'b0});
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chkWord({err, pready, rd[29:0]}, 32'hC000_0000, "unmapped read");
  endtask

  // power-on again with flags possibly set: only this reset may clear them
  task automatic porAgainTest();
    @(posedge mclk);
    sys_rst <= 1'b1;
    powerUp <= 1'b0;
    repeat (20) @(posedge mclk);
    chkCtl(resetCtl, FULL_RST, "power-on outputs again");
    sys_rst <= 1'b0;
    powerUp <= 1'b1;
    powerOnTest();
  endtask

  task automatic pinTest();
    @(posedge mclk) pressButton <= 1'b1;
    repeat (4) @(negedge mclk);
    chkCtl(resetCtl, FULL_RST, "pin reset");
    @(posedge mclk) pressButton <= 1'b0;
    resumeRun(FULL_RST, n);
    stat({CAUSE_PIN, 1'b0, 1'b0});
  endtask

  task automatic uvTest();
    @(posedge mclk) dipMask <= ~SEL_MASK;
    stayRun(20);
    @(posedge mclk) dipMask <= SEL_MASK;
    repeat (UVM) @(posedge mclk);
    dipMask <= '0;
    stayRun(12);
    @(posedge mclk) dipMask <= SEL_MASK;
    repeat (UVM + 8) @(negedge mclk);
    chkCtl(resetCtl, FULL_RST, "long dip");
    @(posedge mclk) dipMask <= '0;
    resumeRun(FULL_RST, n);
    stat({CAUSE_UV, 1'b0, 1'b0});
  endtask

  task automatic wdtTest();
    apb(1'b1, CMD_OFS, 32'h1, rd, err);
    apb(1'b1, CTRL_OFS, 32'h1, rd, err);
    stayRun(20);
    // one tick every WDIV cycles since the enable write
    apb(1'b0, WDTCNT_OFS, 32'h0, rd, err);
    chkWord(rd, 32'(20 / WDIV), "watchdog count");
    // a kick restarts the full period, so the old overflow point passes quietly
    apb(1'b1, CMD_OFS, 32'h1, rd, err);
    n = 0;
    while (resetCtl.cpuRun === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chkWord(32'(n), 32'((1 << WW) * WDIV + 1), "watchdog period");
    chkCtl(resetCtl, FULL_RST, "watchdog reset");
    resumeRun(FULL_RST, n);
    stat({CAUSE_WDT, 1'b0, 1'b1});
  endtask

  task automatic haltTest();
    apb(1'b1, CMD_OFS, 32'h1, rd, err);
    apb(1'b1, CTRL_OFS, 32'h1, rd, err);
    apb(1'b1, CMD_OFS, 32'h2, rd, err);
    @(negedge mclk);
    chkCtl(resetCtl, 5'h00, "power-down");
    n = 0;
    while (resetCtl === 5'h00 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    // halt write lands three cycles after the enable write
    chkWord(32'(n), 32'((1 << WW) * WDIV - 3), "wake time");
    chkCtl(resetCtl, HALT_RST, "wake by watchdog");
    resumeRun(HALT_RST, n);
    stat({CAUSE_WDT_HALT, 1'b1, 1'b1});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    powerUp = 1'b0;
    pressButton = 1'b0;
    dipMask = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    chkCtl(resetCtl, FULL_RST, "power-on outputs");
    sys_rst <= 1'b0;
    powerUp <= 1'b1;
    powerOnTest();
    pinTest();
    uvTest();
    wdtTest();
    porAgainTest();
    haltTest();
    porAgainTest();
    end_of_test();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
endmodule
